// ### src/uco_bit_timer.sv
// Purpose: Bit period counter with end-of-bit and mid-bit strobes
// Assumes: Divisor is the bit length in clock cycles
// Notes: Held at zero while restart is high
`timescale 1ns/100ps
module uco_bit_timer
	import uco_pkg::*;
#(
	parameter int W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic restart,
	input wire logic [W-1:0] divisor,
	output logic tick,
	output logic mid
);

	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic last;

	if (W < 8) begin : g_check
		$error("uco_bit_timer: width below 8");
	end

	// A divisor of zero or one simply ticks every cycle
	assign last = (divisor <= W'(1)) || (cnt_reg >= divisor - W'(1));
	assign tick = ~restart & last;
	assign mid = ~restart & (cnt_reg == (divisor >> 1));

	always_comb begin
		if (restart || last) begin
			cnt_next = '0;
		end else begin
			cnt_next = cnt_reg + W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

endmodule : uco_bit_timer

// ### src/uco_ctrl.sv
// Purpose: Serial transceiver control: registers, framing, break, wake
// Assumes: APB slave, pins synchronous to pclk
// Notes: One character of buffering in each direction
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module uco_ctrl
	import uco_pkg::*;
#(
	parameter int DIV_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output uco_pin_type pins,
	input wire logic rxtx_in,
	input wire logic uart_clk_on,
	output logic irq,
	output logic wake_req
);

	if (DIV_W != 16) begin : g_check
		$error("uco_ctrl: divisor is two bytes wide");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	uco_ctl1_type ctl1_reg, ctl1_next;
	uco_ctl2_type ctl2_reg, ctl2_next;
	logic one_wire_sel_reg, one_wire_sel_next;
	logic [15:0] div_reg, div_next;
	uco_tx_state_type tx_st_reg, tx_st_next;
	logic [3:0] tx_cnt_reg, tx_cnt_next;
	logic [8:0] tx_sh_reg, tx_sh_next;
	logic [7:0] tx_buf_reg, tx_buf_next;
	logic tx_full_reg, tx_full_next;
	logic tx_line_reg, tx_line_next;
	uco_rx_state_type rx_st_reg, rx_st_next;
	logic [3:0] rx_cnt_reg, rx_cnt_next;
	logic [8:0] rx_sh_reg, rx_sh_next;
	logic [7:0] rx_buf_reg, rx_buf_next;
	logic rx_full_reg, rx_full_next;
	logic ovr_reg, ovr_next;
	logic framing_flag_reg, framing_flag_next;
	logic parity_error_flag_reg, parity_error_flag_next;
	logic noise_reg, noise_next;
	logic framing_flag_pend_reg, framing_flag_pend_next;
	logic rx_prev_reg, rx_prev_next;
	logic stat_seen_reg, stat_seen_next;
	logic wake_reg, wake_next;
	logic [31:0] prdata_reg, prdata_next;

	logic glob, tx_en, rx_en, nine;
	logic tx_tick, rx_mid;
	logic wr, rd, hit;
	logic [8:0] frame, word;
	logic [3:0] nbits;
	logic fall;
	uco_stat_type stat;

	assign glob = ctl1_reg.serial_global_on;
	assign nine = ctl1_reg.word_length_sel;
	assign tx_en = glob & ctl2_reg.transmitter_on;
	assign rx_en = glob & ctl2_reg.receiver_on;
	assign nbits = nine ? 4'h9 : 4'h8;
	assign fall = rx_prev_reg & ~rxtx_in;

	// ----------------------------------------
	// Bit timers
	// ----------------------------------------
	// Timers sit at zero while idle or disabled, so the first bit is full length
	uco_bit_timer #(.W(DIV_W)) u_tx_timer (
		.pclk(pclk),
		.presetn(presetn),
		.restart(~tx_en || tx_st_reg == TX_IDLE),
		.divisor(div_reg),
		.tick(tx_tick),
		.mid()
	);

	uco_bit_timer #(.W(DIV_W)) u_rx_timer (
		.pclk(pclk),
		.presetn(presetn),
		.restart(~rx_en || rx_st_reg == RX_IDLE),
		.divisor(div_reg),
		.tick(),
		.mid(rx_mid)
	);

	// ----------------------------------------
	// Bus decode and status view
	// ----------------------------------------
	assign hit = (paddr[1:0] == 2'h0) && (paddr <= OFF_FILL);
	assign wr = psel & penable & pwrite & hit;
	assign rd = psel & penable & ~pwrite & hit;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign prdata = prdata_reg;

	always_comb begin
		stat.parity_error_flag = parity_error_flag_reg;
		stat.noise_flag = noise_reg;
		stat.framing_flag = framing_flag_reg;
		stat.overrun_flag = ovr_reg;
		stat.rx_idle_flag = (rx_st_reg == RX_IDLE);
		stat.rx_avail_flag = rx_full_reg;
		stat.tx_idle_flag = ~tx_full_reg & (tx_st_reg == TX_IDLE);
		stat.tx_empty_flag = ~tx_full_reg;
	end

	// Transmit frame with optional ninth bit and parity in the top position
	always_comb begin
		frame = {nine & ctl1_reg.tx_ninth_bit, tx_buf_reg};
		if (ctl1_reg.parity_on) begin
			if (nine) begin
				frame[8] = uco_parity(frame, 1'b1, ctl1_reg.parity_type);
			end else begin
				frame[7] = uco_parity(frame, 1'b0, ctl1_reg.parity_type);
			end
		end
	end

	// Received word right-aligned regardless of length
	assign word = nine ? rx_sh_reg : {1'b0, rx_sh_reg[8:1]};

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic abit;
		logic pbit;
		abit = 1'b0;
		pbit = 1'b0;
		ctl1_next = ctl1_reg;
		ctl2_next = ctl2_reg;
		one_wire_sel_next = one_wire_sel_reg;
		div_next = div_reg;
		tx_st_next = tx_st_reg;
		tx_cnt_next = tx_cnt_reg;
		tx_sh_next = tx_sh_reg;
		tx_buf_next = tx_buf_reg;
		tx_full_next = tx_full_reg;
		rx_st_next = rx_st_reg;
		rx_cnt_next = rx_cnt_reg;
		rx_sh_next = rx_sh_reg;
		rx_buf_next = rx_buf_reg;
		rx_full_next = rx_full_reg;
		ovr_next = ovr_reg;
		framing_flag_next = framing_flag_reg;
		parity_error_flag_next = parity_error_flag_reg;
		noise_next = noise_reg;
		framing_flag_pend_next = framing_flag_pend_reg;
		rx_prev_next = rxtx_in;
		stat_seen_next = stat_seen_reg;
		wake_next = wake_reg;
		prdata_next = prdata_reg;

		// Register reads are latched in the setup cycle
		if (psel && !penable) begin
			case (paddr)
				OFF_CTL1: prdata_next = {24'h0, ctl1_reg[7:1], 1'b0};
				OFF_CTL2: prdata_next = {24'h0, ctl2_reg};
				OFF_CTL3: prdata_next = {31'h0, one_wire_sel_reg};
				OFF_STAT: prdata_next = {24'h0, stat};
				OFF_DATA: prdata_next = {24'h0, rx_buf_reg};
				OFF_DIVL: prdata_next = {24'h0, div_reg[7:0]};
				OFF_DIVH: prdata_next = {24'h0, div_reg[15:8]};
				OFF_FILL: prdata_next = {31'h0, rx_full_reg};
				default: prdata_next = 32'h0000_0000;
			endcase
		end

		// Software writes and read side effects
		if (wr) begin
			case (paddr)
				OFF_CTL1: begin
					ctl1_next = uco_ctl1_type'(pwdata[7:0]);
					ctl1_next.rx_ninth_bit = ctl1_reg.rx_ninth_bit;
				end
				OFF_CTL2: ctl2_next = uco_ctl2_type'(pwdata[7:0]);
				OFF_CTL3: one_wire_sel_next = pwdata[0];
				OFF_DIVL: div_next[7:0] = pwdata[7:0];
				OFF_DIVH: div_next[15:8] = pwdata[7:0];
				OFF_DATA: begin
					stat_seen_next = 1'b0;
					if (tx_en && !tx_full_reg) begin
						tx_buf_next = pwdata[7:0];
						tx_full_next = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (rd && paddr == OFF_STAT) begin
			stat_seen_next = 1'b1;
		end
		// Status read then data read releases the character and its errors
		if (rd && paddr == OFF_DATA && stat_seen_reg) begin
			stat_seen_next = 1'b0;
			rx_full_next = 1'b0;
			ovr_next = 1'b0;
			framing_flag_next = 1'b0;
			parity_error_flag_next = 1'b0;
			noise_next = 1'b0;
		end

		// Transmitter
		case (tx_st_reg)
			TX_IDLE: begin
				if (tx_full_reg) begin
					tx_sh_next = frame;
					tx_full_next = 1'b0;
					tx_st_next = TX_START;
				end else if (ctl1_reg.send_break) begin
					tx_cnt_next = 4'h0;
					tx_st_next = TX_BREAK;
				end
			end
			TX_START: begin
				if (tx_tick) begin
					tx_cnt_next = 4'h0;
					tx_st_next = TX_DATA;
				end
			end
			TX_DATA: begin
				if (tx_tick) begin
					tx_sh_next = {1'b1, tx_sh_reg[8:1]};
					tx_cnt_next = tx_cnt_reg + 4'h1;
					if (tx_cnt_reg == nbits - 4'h1) begin
						tx_cnt_next = 4'h0;
						tx_st_next = TX_STOP;
					end
				end
			end
			TX_STOP: begin
				if (tx_tick) begin
					tx_cnt_next = tx_cnt_reg + 4'h1;
					if (tx_cnt_reg == TX_RX_STOP_COUNT - 4'h1) begin
						tx_st_next = TX_IDLE;
					end
				end
			end
			TX_BREAK: begin
				// Low for at least the break length, then until software lets go
				if (tx_tick && tx_cnt_reg < BREAK_BITS) begin
					tx_cnt_next = tx_cnt_reg + 4'h1;
				end
				if (tx_cnt_reg >= BREAK_BITS && !ctl1_reg.send_break) begin
					tx_st_next = TX_IDLE;
				end
			end
			default: tx_st_next = TX_IDLE;
		endcase
		if (!tx_en) begin
			tx_st_next = TX_IDLE;
			tx_full_next = 1'b0;
		end

		// Receiver, sampling each bit at its middle
		case (rx_st_reg)
			RX_IDLE: begin
				if (fall) begin
					rx_st_next = RX_START;
				end
			end
			RX_START: begin
				if (rx_mid) begin
					rx_cnt_next = 4'h0;
					framing_flag_pend_next = 1'b0;
					if (rxtx_in) begin
						noise_next = 1'b1;
						rx_st_next = RX_IDLE;
					end else begin
						rx_st_next = RX_DATA;
					end
				end
			end
			RX_DATA: begin
				if (rx_mid) begin
					rx_sh_next = {rxtx_in, rx_sh_reg[8:1]};
					rx_cnt_next = rx_cnt_reg + 4'h1;
					if (rx_cnt_reg == nbits - 4'h1) begin
						rx_cnt_next = 4'h0;
						rx_st_next = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (rx_mid) begin
					rx_cnt_next = rx_cnt_reg + 4'h1;
					if (!rxtx_in) begin
						framing_flag_pend_next = 1'b1;
					end
					if (rx_cnt_reg == {3'h0, ctl2_reg.rx_stop_count}) begin
						rx_st_next = RX_IDLE;
						abit = nine ? word[8] : word[7];
						pbit = nine ? word[8] : word[7];
						if (ctl2_reg.addr_detect_on && !abit) begin
							rx_st_next = RX_IDLE;
						end else if (rx_full_reg && rx_full_next) begin
							ovr_next = 1'b1;
						end else begin
							// Set wins over a release in the same cycle
							rx_full_next = 1'b1;
							framing_flag_next = framing_flag_pend_reg | ~rxtx_in;
							parity_error_flag_next = ctl1_reg.parity_on & (uco_parity(word, nine, ctl1_reg.parity_type) != pbit);
							rx_buf_next = word[7:0];
							if (ctl1_reg.parity_on && !nine) begin
								rx_buf_next[7] = 1'b0;
							end
							if (nine) begin
								ctl1_next.rx_ninth_bit = word[8] & ~ctl1_reg.parity_on;
							end
						end
					end
				end
			end
			default: rx_st_next = RX_IDLE;
		endcase
		if (!rx_en) begin
			rx_st_next = RX_IDLE;
			rx_full_next = 1'b0;
		end

		// Falling edge wake-up only while the serial clock is stopped
		if (uart_clk_on || !ctl2_reg.line_wake_on) begin
			wake_next = 1'b0;
		end else if (fall) begin
			wake_next = 1'b1;
		end

		// Global disable: selected bits cleared, all other settings kept
		if (!glob) begin
			ctl2_next.transmitter_on = 1'b0;
			ctl2_next.receiver_on = 1'b0;
			ctl1_next.send_break = 1'b0;
			rx_full_next = 1'b0;
			tx_full_next = 1'b0;
			ovr_next = 1'b0;
			framing_flag_next = 1'b0;
			parity_error_flag_next = 1'b0;
			noise_next = 1'b0;
			stat_seen_next = 1'b0;
		end

		// Line level follows the next state so the pin comes from a flip-flop
		case (tx_st_next)
			TX_START, TX_BREAK: tx_line_next = 1'b0;
			TX_DATA: tx_line_next = tx_sh_next[0];
			default: tx_line_next = 1'b1;
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl1_reg <= uco_ctl1_type'(CTL1_RST);
			ctl2_reg <= uco_ctl2_type'(CTL2_RST);
			one_wire_sel_reg <= CTL3_RST;
			div_reg <= DIV_RST;
			tx_st_reg <= TX_IDLE;
			tx_cnt_reg <= 4'h0;
			tx_sh_reg <= 9'h1FF;
			tx_buf_reg <= 8'h00;
			tx_full_reg <= 1'b0;
			tx_line_reg <= 1'b1;
			rx_st_reg <= RX_IDLE;
			rx_cnt_reg <= 4'h0;
			rx_sh_reg <= 9'h000;
			rx_buf_reg <= 8'h00;
			rx_full_reg <= 1'b0;
			ovr_reg <= 1'b0;
			framing_flag_reg <= 1'b0;
			parity_error_flag_reg <= 1'b0;
			noise_reg <= 1'b0;
			framing_flag_pend_reg <= 1'b0;
			rx_prev_reg <= 1'b1;
			stat_seen_reg <= 1'b0;
			wake_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			ctl1_reg <= ctl1_next;
			ctl2_reg <= ctl2_next;
			one_wire_sel_reg <= one_wire_sel_next;
			div_reg <= div_next;
			tx_st_reg <= tx_st_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_sh_reg <= tx_sh_next;
			tx_buf_reg <= tx_buf_next;
			tx_full_reg <= tx_full_next;
			tx_line_reg <= tx_line_next;
			rx_st_reg <= rx_st_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_sh_reg <= rx_sh_next;
			rx_buf_reg <= rx_buf_next;
			rx_full_reg <= rx_full_next;
			ovr_reg <= ovr_next;
			framing_flag_reg <= framing_flag_next;
			parity_error_flag_reg <= parity_error_flag_next;
			noise_reg <= noise_next;
			framing_flag_pend_reg <= framing_flag_pend_next;
			rx_prev_reg <= rx_prev_next;
			stat_seen_reg <= stat_seen_next;
			wake_reg <= wake_next;
			prdata_reg <= prdata_next;
		end
	end

	// ----------------------------------------
	// Pins and interrupt request
	// ----------------------------------------
	always_comb begin
		pins.txd_out = tx_line_reg;
		pins.txd_oe_n = ~tx_en;
		pins.rxtx_out = tx_line_reg;
		// Shared pin transmits only in single wire mode with receiver off
		pins.rxtx_oe_n = ~(tx_en & one_wire_sel_reg & ~ctl2_reg.receiver_on);
	end

	assign wake_req = wake_reg;
	assign irq = (ctl2_reg.rx_irq_on & (rx_full_reg | ovr_reg | wake_reg))
		| (ctl2_reg.tx_idle_irq_on & glob & stat.tx_idle_flag)
		| (ctl2_reg.tx_empty_irq_on & glob & stat.tx_empty_flag);

endmodule : uco_ctrl

// ### src/uco_pkg.sv
// Purpose: Shared constants, types and helpers of the serial control block
// Assumes: APB register access, one clock
// Notes: Registers sit on aligned words, data in the low bits
package uco_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] OFF_CTL1 = 8'h00;
	localparam logic [7:0] OFF_CTL2 = 8'h04;
	localparam logic [7:0] OFF_CTL3 = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0C;
	localparam logic [7:0] OFF_DATA = 8'h10;
	localparam logic [7:0] OFF_DIVL = 8'h14;
	localparam logic [7:0] OFF_DIVH = 8'h18;
	localparam logic [7:0] OFF_FILL = 8'h1C;

	localparam logic [7:0] CTL1_RST = 8'h00;
	localparam logic [7:0] CTL2_RST = 8'h00;
	localparam logic CTL3_RST = 1'b0;
	localparam logic [15:0] DIV_RST = 16'h0000;

	// ----------------------------------------
	// Timing and encodings
	// ----------------------------------------
	localparam logic [3:0] BREAK_BITS = 4'hD;
	localparam logic [3:0] TX_RX_STOP_COUNT = 4'h2;
	localparam logic [1:0] PAR_EVEN = 2'h0;
	localparam logic [1:0] PAR_ODD = 2'h1;
	localparam logic [1:0] PAR_MARK = 2'h2;
	localparam logic [1:0] PAR_SPACE = 2'h3;

	typedef struct packed {
		logic serial_global_on;
		logic word_length_sel;
		logic parity_on;
		logic [1:0] parity_type;
		logic send_break;
		logic rx_ninth_bit;
		logic tx_ninth_bit;
	} uco_ctl1_type;

	typedef struct packed {
		logic transmitter_on;
		logic receiver_on;
		logic rx_stop_count;
		logic addr_detect_on;
		logic line_wake_on;
		logic rx_irq_on;
		logic tx_idle_irq_on;
		logic tx_empty_irq_on;
	} uco_ctl2_type;

	typedef struct packed {
		logic parity_error_flag;
		logic noise_flag;
		logic framing_flag;
		logic overrun_flag;
		logic rx_idle_flag;
		logic rx_avail_flag;
		logic tx_idle_flag;
		logic tx_empty_flag;
	} uco_stat_type;

	typedef struct packed {
		logic txd_out;
		logic txd_oe_n;
		logic rxtx_out;
		logic rxtx_oe_n;
	} uco_pin_type;

	typedef enum logic [4:0] {
		TX_IDLE = 5'b00001,
		TX_START = 5'b00010,
		TX_DATA = 5'b00100,
		TX_STOP = 5'b01000,
		TX_BREAK = 5'b10000
	} uco_tx_state_type;

	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA = 4'b0100,
		RX_STOP = 4'b1000
	} uco_rx_state_type;

	// Parity over the bits below the parity position of a 8 or 9 bit word
	function automatic logic uco_parity(input logic [8:0] word, input logic nine, input logic [1:0] kind);
		logic sum;
		sum = nine ? ^word[7:0] : ^word[6:0];
		case (kind)
			PAR_EVEN: uco_parity = sum;
			PAR_ODD: uco_parity = ~sum;
			PAR_MARK: uco_parity = 1'b1;
			default: uco_parity = 1'b0;
		endcase
	endfunction : uco_parity

endpackage : uco_pkg

// ### verification/uco_ctrl_asserts.sv
// Purpose: Port checks of the serial control block
// Assumes: Shadow registers follow APB writes
// Notes: Shadow enables are cleared while the block is off
`timescale 1ns/100ps
module uco_ctrl_chk
	import uco_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire uco_pin_type pins,
	input wire logic rxtx_in,
	input wire logic uart_clk_on,
	input wire logic irq,
	input wire logic wake_req
);
	logic wr, glob_reg, glob_next, swm_reg, swm_next, rxp_reg;
	logic [7:0] c2_reg, c2_next;
	assign wr = psel && penable && pwrite && pready;
	always_comb begin
		glob_next = (wr && paddr == OFF_CTL1) ? pwdata[7] : glob_reg;
		swm_next = (wr && paddr == OFF_CTL3) ? pwdata[0] : swm_reg;
		c2_next = (wr && paddr == OFF_CTL2) ? pwdata[7:0] : c2_reg;
		// Enable writes are lost while the block is off
		if (!glob_reg) c2_next[7:6] = 2'b00;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			glob_reg <= 1'b0;
			swm_reg <= 1'b0;
			c2_reg <= 8'h00;
			rxp_reg <= 1'b0;
		end else begin
			glob_reg <= glob_next;
			swm_reg <= swm_next;
			c2_reg <= c2_next;
			rxp_reg <= rxtx_in;
		end
	end
	// --------
	// Properties
	// --------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	float_off_a: assert property (!glob_reg |-> pins.txd_oe_n && pins.rxtx_oe_n)
		else $error("pins driven while off");
	tx_drive_a: assert property (!pins.txd_oe_n == (glob_reg && c2_reg[7]))
		else $error("transmit pin enable wrong");
	one_wire_a: assert property (!pins.rxtx_oe_n == (glob_reg && c2_reg[7] && swm_reg && !c2_reg[6]))
		else $error("shared pin enable wrong");
	wake_quiet_a: assert property ((uart_clk_on || !c2_reg[3]) |=> !wake_req)
		else $error("wake while not allowed");
	wake_cause_a: assert property ($rose(wake_req) |-> !$past(uart_clk_on) && $past(c2_reg[3]) && !$past(rxtx_in))
		else $error("wake without cause");
	wake_live_a: assert property ((!uart_clk_on && c2_reg[3] && rxp_reg && !rxtx_in) |-> ##[1:3] wake_req)
		else $error("wake missed");
	irq_wake_a: assert property ((wake_req && c2_reg[2]) |-> irq)
		else $error("wake irq missing");
	irq_quiet_a: assert property ((c2_reg[2:0] == 3'h0) |-> !irq)
		else $error("irq while all masked");
	irq_empty_a: assert property ((glob_reg && !c2_reg[7] && c2_reg[0]) [*3] |-> irq)
		else $error("empty irq missing");
endmodule : uco_ctrl_chk

// ### verification/uco_ctrl_bench.sv
// Purpose: Directed tests of the serial control block
// Assumes: Bit length of 16 clocks
// Notes: Remote node model drives the shared line
`timescale 1ns/100ps
module uco_ctrl_bench
	import uco_pkg::*;
;
	localparam int DIV = 16;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxtx_in, uart_clk_on, irq, wake_req, err, p;
	logic [7:0] paddr, d;
	logic [31:0] pwdata, prdata, rd;
	logic [11:0] fr;
	uco_pin_type pins;
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;
	int t;
	uco_ctrl #(.DIV_W(16)) i_uco_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pins(pins), .rxtx_in(rxtx_in), .uart_clk_on(uart_clk_on), .irq(irq), .wake_req(wake_req));
	uco_far_node i_uco_far_node (.pclk(pclk), .txd(pins.txd_oe_n | pins.txd_out), .dev_out(pins.rxtx_out),
		.dev_oe_n(pins.rxtx_oe_n), .line(rxtx_in));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			stop_test();
		end
	end
	// --------
	// Tasks
	// --------
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'b1, a, v);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check($sformatf("register %h", a), e, rd);
	endtask : rdc
	// --------
	// Tests
	// --------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		uart_clk_on = 1'b1;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(OFF_CTL1, 32'h00);
		rdc(OFF_CTL2, 32'h00);
		rdc(OFF_STAT, 32'h0B);
		rdc(OFF_FILL, 32'h00);
		apb(1'b0, 8'h20, 32'h0);
		check("unmapped error", 32'h1, {31'h0, err});
		wr(OFF_DIVL, DIV);
		wr(OFF_DIVH, 32'h00);
		wr(OFF_CTL1, 32'h80);
		wr(OFF_CTL2, 32'h01);
		check("empty irq", 32'h1, {31'h0, irq});
		$display("register test done");
		wr(OFF_CTL2, 32'h80);
		for (int k = 0; k < 4; k++) begin
			d = 8'h8B + 8'(k);
			p = (k == 0) ? ^d[6:0] : (k == 1) ? ~^d[6:0] : (k == 2);
			wr(OFF_CTL1, {24'h0, 3'b101, 2'(k), 3'b000});
			wr(OFF_DATA, {24'h0, d});
			i_uco_far_node.catch(fr, 11, DIV);
			check("parity frame", {21'h0, 2'b11, p, d[6:0], 1'b0}, {20'h0, fr});
		end
		wr(OFF_CTL1, 32'hC1);
		wr(OFF_DATA, 32'h5A);
		i_uco_far_node.catch(fr, 12, DIV);
		check("ninth bit frame", 32'hEB4, {20'h0, fr});
		$display("transmit test done");
		wr(OFF_CTL2, 32'h40);
		wr(OFF_CTL1, 32'hA0);
		i_uco_far_node.send(12'h786, 11, DIV);
		rdc(OFF_FILL, 32'h01);
		rdc(OFF_STAT, 32'h0F);
		rdc(OFF_DATA, 32'h43);
		wr(OFF_CTL2, 32'h60);
		wr(OFF_CTL1, 32'hC0);
		// Second stop bit low must be caught
		i_uco_far_node.send(12'h74A, 12, DIV);
		rdc(OFF_CTL1, 32'hC2);
		rdc(OFF_STAT, 32'h2F);
		rdc(OFF_DATA, 32'hA5);
		wr(OFF_CTL1, 32'h80);
		wr(OFF_CTL2, 32'h54);
		i_uco_far_node.send(12'h224, 10, DIV);
		check("discard irq", 32'h0, {31'h0, irq});
		rdc(OFF_FILL, 32'h00);
		i_uco_far_node.send(12'h324, 10, DIV);
		check("address irq", 32'h1, {31'h0, irq});
		rdc(OFF_FILL, 32'h01);
		$display("receive test done");
		wr(OFF_CTL3, 32'h01);
		wr(OFF_CTL2, 32'hF4);
		check("shared pin float", 32'h1, {31'h0, pins.rxtx_oe_n});
		wr(OFF_DATA, 32'h55);
		repeat (3 * DIV) @(posedge pclk);
		wr(OFF_CTL1, 32'h00);
		check("pins float", 32'h3, {30'h0, pins.txd_oe_n, pins.rxtx_oe_n});
		rdc(OFF_CTL2, 32'h34);
		rdc(OFF_STAT, 32'h0B);
		rdc(OFF_FILL, 32'h00);
		rdc(OFF_DIVL, DIV);
		rdc(OFF_CTL3, 32'h01);
		wr(OFF_CTL1, 32'h80);
		wr(OFF_CTL2, 32'h80);
		t = 0;
		repeat (12 * DIV) begin
			@(posedge pclk);
			if (pins.txd_out !== 1'b1) t++;
		end
		check("no resumed frame", 32'h0, t);
		$display("disable test done");
		wr(OFF_CTL1, 32'h84);
		t = 0;
		while (pins.txd_out !== 1'b0 && t < 4 * DIV) begin
			@(posedge pclk);
			t++;
		end
		t = 0;
		fork
			begin
				repeat (2 * DIV) @(posedge pclk);
				// Transmitter only in single wire mode, so the shared line carries the break too
				check("shared line break", 32'h0, {31'h0, rxtx_in});
				wr(OFF_CTL1, 32'h80);
			end
			while (pins.txd_out === 1'b0 && t < 40 * DIV) begin
				@(posedge pclk);
				t++;
			end
		join
		check("break length", 32'h1, {31'h0, t >= 13 * DIV - 2 && t < 40 * DIV});
		wr(OFF_CTL2, 32'h82);
		check("idle irq", 32'h1, {31'h0, irq});
		wr(OFF_DATA, 32'h3C);
		check("busy irq", 32'h0, {31'h0, irq});
		repeat (12 * DIV) @(posedge pclk);
		check("done irq", 32'h1, {31'h0, irq});
		$display("break test done");
		uart_clk_on <= 1'b0;
		wr(OFF_CTL2, 32'h04);
		i_uco_far_node.send(12'h000, 1, DIV);
		check("wake while off", 32'h0, {31'h0, wake_req});
		wr(OFF_CTL2, 32'h0C);
		i_uco_far_node.send(12'h000, 1, DIV);
		check("wake request", 32'h3, {30'h0, wake_req, irq});
		uart_clk_on <= 1'b1;
		repeat (2) @(posedge pclk);
		check("wake with clock", 32'h0, {31'h0, wake_req});
		$display("wake test done");
		stop_test();
	end
endmodule : uco_ctrl_bench
bind uco_ctrl uco_ctrl_chk i_uco_ctrl_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pins(pins), .rxtx_in(rxtx_in),
	.uart_clk_on(uart_clk_on), .irq(irq), .wake_req(wake_req));

// ### verification/uco_far_node.sv
// Purpose: Remote serial node on the shared line
// Assumes: Bit length given in clock cycles
// Notes: Line pulled high when nobody drives it
`timescale 1ns/100ps
module uco_far_node (
	input wire logic pclk,
	input wire logic txd,
	input wire logic dev_out,
	input wire logic dev_oe_n,
	output logic line
);
	logic drv_reg = 1'b1;
	assign line = dev_oe_n ? drv_reg : dev_out;
	// --------
	// Frame tasks, bit 0 is sent first
	// --------
	task automatic send(input logic [11:0] bits, input int n, input int div);
		for (int i = 0; i < n; i++) begin
			drv_reg <= bits[i];
			repeat (div) @(posedge pclk);
		end
		drv_reg <= 1'b1;
	endtask : send
	task automatic catch(output logic [11:0] bits, input int n, input int div);
		int t;
		bits = 12'h000;
		t = 0;
		while (txd !== 1'b0 && t < 4000) begin
			@(posedge pclk);
			t++;
		end
		// Sample in the middle of each bit
		repeat (div / 2) @(posedge pclk);
		for (int i = 0; i < n; i++) begin
			bits[i] = txd;
			repeat (div) @(posedge pclk);
		end
	endtask : catch
endmodule : uco_far_node
